// [verilog/srfc_defs.vh]
// How it works
// - 13-bit interval counter loads rate at reset and rate write, counts memory clocks.
// - At one or below the interval counter reloads the current rate and keeps counting.
// - Each interval expiry raises the 4-bit backlog unless it is already full.
// - Each auto refresh performed, except the eight of the init burst, lowers the backlog by one.
// - Backlog saturates at zero and fifteen, never wrapping.
// - An auto refresh is a precharge-all followed by an auto refresh command.
// - Counting and refreshing always run; there is no disable.
// - Backlog 1-3: refresh only when idle with no request and no open bank.
// - Backlog 4-7: refresh when no request pends, open banks get closed.
// - Backlog 8-11: refresh after current access unless reads pend.
// - Backlog 12-15: back-to-back refreshes until level 4-7, holding new requests.
// - Writing SDRAM characteristics reruns initialization with the current rate.
// - Writes to low three config bytes restart init; upper-byte-only writes do not.
// - Init issues no-ops for eight rate-length intervals, after a precharge-all first if a bank is open.
`ifndef SRFC_DEFS_VH
`define SRFC_DEFS_VH

// ----------------------------------------
// Register map, word index times four
// ----------------------------------------
`define SRFC_IDX_CFG 3'h0
`define SRFC_IDX_RFC 3'h1
`define SRFC_IDX_TIM 3'h2
`define SRFC_IDX_SRX 3'h3
`define SRFC_IDX_STAT 3'h4
`define SRFC_IDX_LO 2
`define SRFC_IDX_HI 4
`define SRFC_CFG_RST 32'h00000000
`define SRFC_TIM_RST 32'h00000000
`define SRFC_SRX_RST 32'h00000000
`define SRFC_RR_RST 13'h0100
`define SRFC_SR_BIT 31
`define SRFC_RESP_OKAY 2'h0
`define SRFC_RESP_DECERR 2'h3
`define SRFC_ZERO32 32'h00000000

// ----------------------------------------
// Counters and levels
// ----------------------------------------
`define SRFC_CNT_ONE 13'h0001
`define SRFC_IVL_LAST 3'h7
`define SRFC_REF_LAST 3'h7
`define SRFC_BL_ZERO 4'h0
`define SRFC_BL_MAX 4'hf
`define SRFC_LVL_MAY 2'h0
`define SRFC_LVL_REL 2'h1
`define SRFC_LVL_NEED 2'h2
`define SRFC_LVL_MUST 2'h3

// ----------------------------------------
// SDRAM commands
// ----------------------------------------
`define SRFC_CMD_NOP 2'h0
`define SRFC_CMD_PRE 2'h1
`define SRFC_CMD_REF 2'h2
`define SRFC_CMD_LMR 2'h3

`endif

// [verilog/srfc_sync.v]
`default_nettype none
module srfc_sync (
	input wire aclk,
	input wire aresetn,
	input wire din,
	output wire dout
);
	reg s1_r;
	reg s2_r;
	always @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
		end
	end
	assign dout = s2_r;
endmodule
`default_nettype wire

// [verilog/srfc_backlog.v]
`include "srfc_defs.vh"
`default_nettype none
module srfc_backlog (
	input wire aclk,
	input wire aresetn,
	input wire inc,
	input wire dec,
	output reg [3:0] count_r
);
	always @(posedge aclk) begin
		if (!aresetn) begin
			count_r <= `SRFC_BL_ZERO;
		end else if (inc && !dec) begin
			if (count_r != `SRFC_BL_MAX) begin
				count_r <= count_r + 4'h1;
			end
		end else if (dec && !inc) begin
			if (count_r != `SRFC_BL_ZERO) begin
				count_r <= count_r - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [verilog/srfc_top.v]
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`include "srfc_defs.vh"
`default_nettype none
module srfc_top (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire memory_clock,
	input wire rd_req_pending,
	input wire wr_req_pending,
	input wire access_busy,
	input wire bank_open,
	output reg access_allow_r,
	output reg [1:0] sdram_cmd_r,
	output reg sdram_a10_r,
	output reg sdram_clock_enable_pin_r,
	output reg self_refresh_request_r
);
	// ----------------------------------------
	// State codes
	// ----------------------------------------
	localparam [2:0] INIT_IDLE = 3'h0;
	localparam [2:0] INIT_OPRE = 3'h1;
	localparam [2:0] INIT_WAIT = 3'h2;
	localparam [2:0] INIT_PRE = 3'h3;
	localparam [2:0] INIT_REFS = 3'h4;
	localparam [2:0] INIT_LMR = 3'h5;
	localparam [2:0] INIT_FPRE = 3'h6;
	localparam [2:0] INIT_FREF = 3'h7;
	localparam RF_IDLE = 1'b0;
	localparam RF_REF = 1'b1;

	// ----------------------------------------
	// Memory clock edge detection
	// ----------------------------------------
	wire mclk_s;
	reg mclk_d_r;
	wire tick;
	srfc_sync u_mclk_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din(memory_clock),
		.dout(mclk_s)
	);
	always @(posedge aclk) begin
		if (!aresetn) begin
			mclk_d_r <= 1'b0;
		end else begin
			mclk_d_r <= mclk_s;
		end
	end
	assign tick = mclk_s & ~mclk_d_r;

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	reg aw_have_r;
	reg w_have_r;
	reg [31:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	reg [31:0] cfg_r;
	reg [12:0] rr_r;
	reg [31:0] tim_r;
	reg [31:0] srx_r;
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire aw_hn = aw_have_r | aw_take;
	wire w_hn = w_have_r | w_take;
	wire wr_do = aw_hn & w_hn;
	wire [31:0] wa = aw_take ? s_axi_awaddr : aw_addr_r;
	wire [31:0] wd = w_take ? s_axi_wdata : w_data_r;
	wire [3:0] ws = w_take ? s_axi_wstrb : w_strb_r;
	wire [2:0] widx = wa[`SRFC_IDX_HI:`SRFC_IDX_LO];
	wire wa_hi_ok = (wa[31:5] == 27'h0000000) && (wa[1:0] == 2'h0);
	wire wmap = wa_hi_ok && (widx <= `SRFC_IDX_STAT);
	wire bvalid_nxt = wr_do | (s_axi_bvalid & ~s_axi_bready);
	wire rvalid_nxt = ar_take | (s_axi_rvalid & ~s_axi_rready);
	wire cfg_wr = wr_do && wa_hi_ok && (widx == `SRFC_IDX_CFG);
	wire init_start = cfg_wr && (ws[2:0] != 3'h0);
	wire rr_wr = wr_do && wa_hi_ok && (widx == `SRFC_IDX_RFC) && (ws[1:0] != 2'h0);
	wire [12:0] rr_wval = {ws[1] ? wd[12:8] : rr_r[12:8], ws[0] ? wd[7:0] : rr_r[7:0]};

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= `SRFC_ZERO32;
			w_data_r <= `SRFC_ZERO32;
			w_strb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SRFC_RESP_OKAY;
			cfg_r <= `SRFC_CFG_RST;
			rr_r <= `SRFC_RR_RST;
			tim_r <= `SRFC_TIM_RST;
			srx_r <= `SRFC_SRX_RST;
			self_refresh_request_r <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_addr_r <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			aw_have_r <= aw_hn & ~wr_do;
			w_have_r <= w_hn & ~wr_do;
			s_axi_awready <= ~(aw_hn & ~wr_do) & ~bvalid_nxt;
			s_axi_wready <= ~(w_hn & ~wr_do) & ~bvalid_nxt;
			s_axi_bvalid <= bvalid_nxt;
			if (wr_do) begin
				s_axi_bresp <= wmap ? `SRFC_RESP_OKAY : `SRFC_RESP_DECERR;
			end
			if (cfg_wr) begin
				cfg_r[7:0] <= ws[0] ? wd[7:0] : cfg_r[7:0];
				cfg_r[15:8] <= ws[1] ? wd[15:8] : cfg_r[15:8];
				cfg_r[23:16] <= ws[2] ? wd[23:16] : cfg_r[23:16];
				cfg_r[31:24] <= ws[3] ? wd[31:24] : cfg_r[31:24];
				if (ws[3]) begin
					self_refresh_request_r <= wd[`SRFC_SR_BIT];
				end
			end
			if (rr_wr) begin
				rr_r <= rr_wval;
			end
			if (wr_do && wa_hi_ok && widx == `SRFC_IDX_TIM) begin
				tim_r[7:0] <= ws[0] ? wd[7:0] : tim_r[7:0];
				tim_r[15:8] <= ws[1] ? wd[15:8] : tim_r[15:8];
				tim_r[23:16] <= ws[2] ? wd[23:16] : tim_r[23:16];
				tim_r[31:24] <= ws[3] ? wd[31:24] : tim_r[31:24];
			end
			if (wr_do && wa_hi_ok && widx == `SRFC_IDX_SRX) begin
				srx_r[7:0] <= ws[0] ? wd[7:0] : srx_r[7:0];
				srx_r[15:8] <= ws[1] ? wd[15:8] : srx_r[15:8];
				srx_r[23:16] <= ws[2] ? wd[23:16] : srx_r[23:16];
				srx_r[31:24] <= ws[3] ? wd[31:24] : srx_r[31:24];
			end
		end
	end

	// ----------------------------------------
	// Refresh interval counter
	// ----------------------------------------
	reg [12:0] ivl_cnt_r;
	wire expire = tick & ~rr_wr & (ivl_cnt_r <= `SRFC_CNT_ONE);
	always @(posedge aclk) begin
		if (!aresetn) begin
			ivl_cnt_r <= `SRFC_RR_RST;
		end else if (rr_wr) begin
			ivl_cnt_r <= rr_wval;
		end else if (tick) begin
			if (ivl_cnt_r <= `SRFC_CNT_ONE) begin
				ivl_cnt_r <= rr_r;
			end else begin
				ivl_cnt_r <= ivl_cnt_r - `SRFC_CNT_ONE;
			end
		end
	end

	// ----------------------------------------
	// Backlog and urgency
	// ----------------------------------------
	wire [3:0] backlog;
	reg bl_dec;
	reg must_mode_r;
	reg ref_go;
	srfc_backlog u_backlog (
		.aclk(aclk),
		.aresetn(aresetn),
		.inc(expire),
		.dec(bl_dec),
		.count_r(backlog)
	);
	wire [1:0] lvl = backlog[3:2];
	wire no_req = ~rd_req_pending & ~wr_req_pending;
	always @* begin
		ref_go = 1'b0;
		if (must_mode_r) begin
			ref_go = ~access_busy;
		end else begin
			case (lvl)
				`SRFC_LVL_MAY: ref_go = (backlog != `SRFC_BL_ZERO) & no_req & ~bank_open & ~access_busy;
				`SRFC_LVL_REL: ref_go = no_req & ~access_busy;
				`SRFC_LVL_NEED: ref_go = ~access_busy & ~rd_req_pending;
				`SRFC_LVL_MUST: ref_go = ~access_busy;
				default: ref_go = 1'b0;
			endcase
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			must_mode_r <= 1'b0;
		end else if (lvl == `SRFC_LVL_MUST) begin
			must_mode_r <= 1'b1;
		end else if (!lvl[1]) begin
			must_mode_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Command sequencer
	// ----------------------------------------
	reg [2:0] init_st_r;
	reg ref_st_r;
	reg [12:0] init_cnt_r;
	reg [2:0] init_ivl_r;
	reg [2:0] init_refs_r;
	always @* begin
		bl_dec = 1'b0;
		if (tick && !init_start) begin
			if (init_st_r == INIT_FREF) begin
				bl_dec = 1'b1;
			end else if (init_st_r == INIT_IDLE && ref_st_r == RF_REF) begin
				bl_dec = 1'b1;
			end
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			init_st_r <= INIT_WAIT;
			ref_st_r <= RF_IDLE;
			init_cnt_r <= `SRFC_RR_RST;
			init_ivl_r <= 3'h0;
			init_refs_r <= 3'h0;
			sdram_cmd_r <= `SRFC_CMD_NOP;
			sdram_a10_r <= 1'b0;
			sdram_clock_enable_pin_r <= 1'b0;
			access_allow_r <= 1'b0;
		end else begin
			sdram_clock_enable_pin_r <= 1'b1;
			if (init_start) begin
				init_st_r <= bank_open ? INIT_OPRE : INIT_WAIT;
				ref_st_r <= RF_IDLE;
				init_cnt_r <= rr_r;
				init_ivl_r <= 3'h0;
				sdram_cmd_r <= tick ? `SRFC_CMD_NOP : sdram_cmd_r;
			end else if (tick) begin
				sdram_cmd_r <= `SRFC_CMD_NOP;
				sdram_a10_r <= 1'b0;
				case (init_st_r)
					INIT_IDLE: begin
						if (ref_st_r == RF_REF) begin
							sdram_cmd_r <= `SRFC_CMD_REF;
							ref_st_r <= RF_IDLE;
						end else if (ref_go) begin
							sdram_cmd_r <= `SRFC_CMD_PRE;
							sdram_a10_r <= 1'b1;
							ref_st_r <= RF_REF;
						end
					end
					INIT_OPRE: begin
						sdram_cmd_r <= `SRFC_CMD_PRE;
						sdram_a10_r <= 1'b1;
						init_st_r <= INIT_WAIT;
					end
					INIT_WAIT: begin
						if (init_cnt_r <= `SRFC_CNT_ONE) begin
							init_cnt_r <= rr_r;
							init_ivl_r <= init_ivl_r + 3'h1;
							if (init_ivl_r == `SRFC_IVL_LAST) begin
								init_st_r <= INIT_PRE;
							end
						end else begin
							init_cnt_r <= init_cnt_r - `SRFC_CNT_ONE;
						end
					end
					INIT_PRE: begin
						sdram_cmd_r <= `SRFC_CMD_PRE;
						sdram_a10_r <= 1'b1;
						init_refs_r <= 3'h0;
						init_st_r <= INIT_REFS;
					end
					INIT_REFS: begin
						sdram_cmd_r <= `SRFC_CMD_REF;
						init_refs_r <= init_refs_r + 3'h1;
						if (init_refs_r == `SRFC_REF_LAST) begin
							init_st_r <= INIT_LMR;
						end
					end
					INIT_LMR: begin
						sdram_cmd_r <= `SRFC_CMD_LMR;
						init_st_r <= INIT_FPRE;
					end
					INIT_FPRE: begin
						sdram_cmd_r <= `SRFC_CMD_PRE;
						sdram_a10_r <= 1'b1;
						init_st_r <= INIT_FREF;
					end
					INIT_FREF: begin
						sdram_cmd_r <= `SRFC_CMD_REF;
						init_st_r <= INIT_IDLE;
					end
					default: init_st_r <= INIT_IDLE;
				endcase
			end
			access_allow_r <= (init_st_r == INIT_IDLE) & ~init_start & ~must_mode_r
				& (ref_st_r == RF_IDLE) & ~(lvl == `SRFC_LVL_MUST);
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	wire [2:0] ridx = s_axi_araddr[`SRFC_IDX_HI:`SRFC_IDX_LO];
	wire ra_ok = (s_axi_araddr[31:5] == 27'h0000000) && (s_axi_araddr[1:0] == 2'h0);
	reg [31:0] rd_mux;
	always @* begin
		rd_mux = `SRFC_ZERO32;
		case (ridx)
			`SRFC_IDX_CFG: rd_mux = cfg_r;
			`SRFC_IDX_RFC: rd_mux = {19'h00000, rr_r};
			`SRFC_IDX_TIM: rd_mux = tim_r;
			`SRFC_IDX_SRX: rd_mux = srx_r;
			`SRFC_IDX_STAT: rd_mux = {21'h000000, must_mode_r, ref_st_r,
				init_st_r != INIT_IDLE, 2'h0, lvl, backlog};
			default: rd_mux = `SRFC_ZERO32;
		endcase
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `SRFC_ZERO32;
			s_axi_rresp <= `SRFC_RESP_OKAY;
		end else begin
			s_axi_arready <= ~rvalid_nxt;
			s_axi_rvalid <= rvalid_nxt;
			if (ar_take) begin
				if (ra_ok && ridx <= `SRFC_IDX_STAT) begin
					s_axi_rdata <= rd_mux;
					s_axi_rresp <= `SRFC_RESP_OKAY;
				end else begin
					s_axi_rdata <= `SRFC_ZERO32;
					s_axi_rresp <= `SRFC_RESP_DECERR;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [tb/srfc_props.sv]
`include "srfc_defs.vh"
`default_nettype none
module srfc_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic memory_clock,
	input wire logic access_allow_r,
	input wire logic [1:0] sdram_cmd_r,
	input wire logic sdram_a10_r,
	input wire logic sdram_clock_enable_pin_r
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------
	// Properties
	// ----------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_pre_all: assert property (sdram_cmd_r == `SRFC_CMD_PRE |-> sdram_a10_r)
		else $error("precharge not to all banks");
	a_ref_after_pre: assert property ((sdram_cmd_r == `SRFC_CMD_REF &&
		$past(sdram_cmd_r) != `SRFC_CMD_REF) |-> $past(sdram_cmd_r) == `SRFC_CMD_PRE)
		else $error("refresh without precharge");
	a_cke_stays: assert property ($past(aresetn) |-> sdram_clock_enable_pin_r)
		else $error("clock enable dropped");
	a_init_blocks: assert property (sdram_cmd_r == `SRFC_CMD_LMR |-> !access_allow_r)
		else $error("access allowed during init");
	// Two synchroniser flops and the command register place a change three cycles after the rise.
	a_cmd_on_tick: assert property ($changed(sdram_cmd_r) |->
		$past(memory_clock, 2) || $past(memory_clock, 3))
		else $error("command changed off tick");
	a_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer stands");
	a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer not released");
	c_refresh: cover property ($rose(sdram_cmd_r == `SRFC_CMD_REF));
	c_lmr: cover property ($rose(sdram_cmd_r == `SRFC_CMD_LMR));
	c_hold: cover property ($fell(access_allow_r));
endmodule
bind srfc_top srfc_props srfc_props_i (.aclk(aclk), .aresetn(aresetn),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.memory_clock(memory_clock), .access_allow_r(access_allow_r), .sdram_cmd_r(sdram_cmd_r),
	.sdram_a10_r(sdram_a10_r), .sdram_clock_enable_pin_r(sdram_clock_enable_pin_r));
`default_nettype wire

// [tb/srfc_sdram_model.sv]
`include "srfc_defs.vh"
`default_nettype none
module srfc_sdram_model (
	output logic memory_clock,
	input wire logic [1:0] sdram_cmd_r,
	input wire logic sdram_a10_r,
	output logic [15:0] ref_cnt,
	output logic bad_seq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] last_cmd;
	// The memory clock runs free, so refresh keeps going with no traffic.
	initial begin
		memory_clock = 1'b0;
		ref_cnt = 16'h0000;
		bad_seq = 1'b0;
		last_cmd = `SRFC_CMD_NOP;
		#3;
		forever #24 memory_clock = ~memory_clock;
	end
	// Sampling mid-period sees each command once, after it has settled.
	always @(negedge memory_clock) begin
		if (sdram_cmd_r == `SRFC_CMD_REF) begin
			ref_cnt <= ref_cnt + 16'h0001;
			if (last_cmd != `SRFC_CMD_PRE && last_cmd != `SRFC_CMD_REF) begin
				bad_seq <= 1'b1;
			end
		end
		if (sdram_cmd_r == `SRFC_CMD_PRE && !sdram_a10_r) begin
			bad_seq <= 1'b1;
		end
		last_cmd <= sdram_cmd_r;
	end
endmodule
`default_nettype wire

// [tb/srfc_top_test.sv]
`default_nettype none
module srfc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	// Rate rounded up: 1920 ns refresh period, one command, 48 ns memory clock.
	localparam logic [31:0] RUN_RR = (32'h00000780 + 32'h0000002f) / 32'h00000030;
	logic aclk, aresetn, memory_clock, bad_seq;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, sdram_cmd_r, resp;
	logic rd_req_pending, wr_req_pending, access_busy, bank_open;
	logic access_allow_r, sdram_a10_r, sdram_clock_enable_pin_r, self_refresh_request_r;
	logic [15:0] ref_cnt, ref_seen;
	int mismatches, checked;
	srfc_top srfc_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .memory_clock(memory_clock),
		.rd_req_pending(rd_req_pending), .wr_req_pending(wr_req_pending),
		.access_busy(access_busy), .bank_open(bank_open), .access_allow_r(access_allow_r),
		.sdram_cmd_r(sdram_cmd_r), .sdram_a10_r(sdram_a10_r),
		.sdram_clock_enable_pin_r(sdram_clock_enable_pin_r),
		.self_refresh_request_r(self_refresh_request_r));
	srfc_sdram_model srfc_sdram_model_i (.memory_clock(memory_clock),
		.sdram_cmd_r(sdram_cmd_r), .sdram_a10_r(sdram_a10_r), .ref_cnt(ref_cnt),
		.bad_seq(bad_seq));
	// -----
	// Tasks
	// -----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [31:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Polls status until the masked field matches, then compares it.
	task automatic wait_st(input logic [31:0] m, input logic [31:0] exp);
		int n;
		n = 0;
		do begin
			axi_rd(32'h00000010);
			n++;
		end while ((rd & m) !== exp && n < 4000);
		check(rd & m, exp);
	endtask
	task automatic close_out;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	initial begin
		#300000;
		mismatches++;
		close_out;
	end
	// -----
	// Tests
	// -----
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 100'h0;
		{rd_req_pending, wr_req_pending, access_busy, bank_open} = 4'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(32'h00000004);
		check(rd & 32'h00001fff, 32'h00000100);
		axi_rd(32'h00000008);
		check(rd, 32'h00000000);
		axi_rd(32'h00000010);
		check(rd & 32'h00000100, 32'h00000100);
		axi_wr(32'h00000008, 32'h00001234, 4'hf);
		axi_wr(32'h00000004, 32'h00000004, 4'hf);
		axi_wr(32'h00000000, 32'h00000321, 4'hf);
		wait_st(32'h00000100, 32'h00000000);
		axi_wr(32'h00000004, RUN_RR, 4'hf);
		rd_req_pending <= 1'b1;
		access_busy <= 1'b1;
		wait_st(32'h0000000f, 32'h0000000f);
		ref_seen = ref_cnt;
		repeat (900) @(posedge aclk);
		axi_rd(32'h00000010);
		check(rd & 32'h0000043f, 32'h0000043f);
		check({31'h0, access_allow_r}, 32'h0);
		check({16'h0, ref_cnt}, {16'h0, ref_seen});
		access_busy <= 1'b0;
		wait_st(32'h0000003f, 32'h00000017);
		repeat (2) @(posedge aclk);
		check({31'h0, access_allow_r}, 32'h1);
		repeat (20) @(posedge aclk);
		ref_seen = ref_cnt;
		wait_st(32'h0000000f, 32'h00000009);
		check({16'h0, ref_cnt}, {16'h0, ref_seen});
		rd_req_pending <= 1'b0;
		wr_req_pending <= 1'b1;
		wait_st(32'h0000003f, 32'h00000017);
		wr_req_pending <= 1'b0;
		bank_open <= 1'b1;
		wait_st(32'h0000000f, 32'h00000003);
		bank_open <= 1'b0;
		wait_st(32'h0000000f, 32'h00000000);
		axi_wr(32'h00000000, 32'h80000000, 4'h8);
		check({31'h0, self_refresh_request_r}, 32'h1);
		axi_rd(32'h00000010);
		check(rd & 32'h00000100, 32'h00000000);
		axi_wr(32'h00000000, 32'h00000000, 4'h8);
		check({31'h0, self_refresh_request_r}, 32'h0);
		axi_rd(32'h00000010);
		check(rd & 32'h00000100, 32'h00000000);
		axi_wr(32'h00000000, 32'h00000321, 4'h1);
		axi_rd(32'h00000010);
		check(rd & 32'h00000100, 32'h00000100);
		axi_rd(32'h00000000);
		check(rd, 32'h00000321);
		axi_wr(32'h00000020, 32'h00000001, 4'hf);
		check({30'h0, resp}, 32'h00000003);
		axi_rd(32'h00000020);
		check(rd | {30'h0, resp}, 32'h00000003);
		check({31'h0, bad_seq}, 32'h0);
		close_out;
	end
endmodule
`default_nettype wire
